// *** common/dtc_pkg.sv ***
// dual 8-bit timer control: register map, field layout, codes and helpers
// assumes an 8-bit register port and a single system clock
package dtc_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] DTC_OFS_FIRST_CTRL  = 8'h1A;
	localparam logic [7:0] DTC_OFS_SECOND_CTRL = 8'h1B;
	localparam logic [7:0] DTC_OFS_FIRST_CMP   = 8'h1C;
	localparam logic [7:0] DTC_OFS_FIRST_PW    = 8'h1D;
	localparam logic [7:0] DTC_OFS_SECOND_CMP  = 8'h1E;
	localparam logic [7:0] DTC_OFS_SECOND_PW   = 8'h1F;
	localparam logic [7:0] DTC_OFS_FIRST_CNT   = 8'h20;
	localparam logic [7:0] DTC_OFS_SECOND_CNT  = 8'h21;

	// ==========================================================
	// field layout and reset values
	localparam int         DTC_FF_BIT     = 7;
	localparam int         DTC_CK_LSB     = 4;
	localparam int         DTC_START_BIT  = 3;
	localparam int         DTC_MODE_LSB   = 0;
	localparam logic [7:0] DTC_CTRL_RST   = 8'h00;
	localparam logic [7:0] DTC_TREG_RST   = 8'h00;
	localparam logic [7:0] DTC_CNT_MAX    = 8'hFF;
	localparam int         DTC_PRE_W      = 11;
	localparam int         DTC_FS_DIV_W   = 3;

	// ==========================================================
	// clock-select codes
	localparam logic [2:0] DTC_CK_DIV11 = 3'h0;
	localparam logic [2:0] DTC_CK_DIV7  = 3'h1;
	localparam logic [2:0] DTC_CK_DIV5  = 3'h2;
	localparam logic [2:0] DTC_CK_DIV3  = 3'h3;
	localparam logic [2:0] DTC_CK_FS    = 3'h4;
	localparam logic [2:0] DTC_CK_DIV1  = 3'h5;
	localparam logic [2:0] DTC_CK_FC    = 3'h6;
	localparam logic [2:0] DTC_CK_RSVD  = 3'h7;

	// ==========================================================
	// mode codes
	localparam logic [2:0] DTC_M1_TIMER8  = 3'h0;
	localparam logic [2:0] DTC_M1_CASCADE = 3'h3;
	localparam logic [2:0] DTC_M2_TIMER8  = 3'h0;
	localparam logic [2:0] DTC_M2_PDO     = 3'h1;
	localparam logic [2:0] DTC_M2_PWM8    = 3'h2;
	localparam logic [2:0] DTC_M2_RSVD    = 3'h3;
	localparam logic [2:0] DTC_M2_TIMER16 = 3'h4;
	localparam logic [2:0] DTC_M2_WARMUP  = 3'h5;
	localparam logic [2:0] DTC_M2_PWM16   = 3'h6;

	typedef logic [7:0] dtc_byte_t;
	typedef enum logic {DTC_STOPPED, DTC_COUNTING} dtc_run_e;

	function automatic logic [2:0] dtc_ck_of(input dtc_byte_t c);
		return c[DTC_CK_LSB +: 3];
	endfunction

	function automatic logic [2:0] dtc_mode_of(input dtc_byte_t c);
		return c[DTC_MODE_LSB +: 3];
	endfunction

	function automatic logic dtc_start_of(input dtc_byte_t c);
		return c[DTC_START_BIT];
	endfunction

endpackage

// *** hdl/dtc_src_sel.sv ***
// source clock selector for one counter: turns a clock-select code into a
// one-cycle count enable; taps are one-cycle pulses in the system clock domain
`timescale 1ns/1ps
module dtc_src_sel
	import dtc_pkg::*;
(
	// selection
	input  wire logic [2:0] i_code,
	input  wire logic       i_divider_source_option,
	input  wire logic       i_slow_mode,
	input  wire logic       i_warmup_ok,
	// taps
	input  wire logic       i_fc_div11,
	input  wire logic       i_fc_div7,
	input  wire logic       i_fc_div5,
	input  wire logic       i_fc_div3,
	input  wire logic       i_fc_div1,
	input  wire logic       i_fs_tick,
	input  wire logic       i_fs_div3,
	// result
	output logic            o_tick
);

	// ==========================================================
	// selection
	always_comb begin
		o_tick = 1'b0;
		if (i_slow_mode) begin
			// only the slow-capable sources; fc only for warm-up
			case (i_code)
				DTC_CK_DIV11: o_tick = i_fs_div3;
				DTC_CK_FS:    o_tick = i_fs_tick;
				DTC_CK_FC:    o_tick = i_warmup_ok;
				default:      o_tick = 1'b0;
			endcase
		end else begin
			case (i_code)
				DTC_CK_DIV11: o_tick = i_divider_source_option ? i_fs_div3 : i_fc_div11;
				DTC_CK_DIV7:  o_tick = i_fc_div7;
				DTC_CK_DIV5:  o_tick = i_fc_div5;
				DTC_CK_DIV3:  o_tick = i_fc_div3;
				DTC_CK_FS:    o_tick = i_fs_tick;
				DTC_CK_DIV1:  o_tick = i_fc_div1;
				DTC_CK_FC:    o_tick = 1'b1;
				default:      o_tick = 1'b0;
			endcase
		end
	end

endmodule // dtc_src_sel

// *** hdl/dtc_timer_ctrl.sv ***
// dual 8-bit timer control: registers, source selection, start/stop, cascade
// assumes fc is the system clock and fs arrives as a synchronous one-cycle tick
// Contract
// (R1) first clock-select: 000 fc/2^11 or fs/2^3 ... 110 fc, 111 reserved.
// (R2) slow/sleep: only codes 000, 100, 110; fc only for warm-up.
// (R3) start bit 0 halts and clears the counter; 1 starts counting.
// (R4) first mode 000 is 8-bit, 011 is cascade; others reserved.
// (R5) cascade needs first mode 011; second mode picks the 16-bit mode.
// (R6) cascade: first clock select; second start bit and flip-flop bit govern.
// (R7) software keeps first mode, clock select, flip-flop bit while running.
// (R8) fields may change with start 0-to-1, not with start 1-to-0.
// (R9) software keeps compare registers unchanged while running.
// (R10) pulse-width register rewritable while running only in PWM modes.
// (R11) each counter: one control, one compare and one pulse-width register.
// (R12) second clock-select uses the first counter's encoding.
// (R13) second mode codes: timer, divider, PWM8, reserved, timer16, warm-up, PWM16.
// (R14) second mode top bit set: second counts first counter overflows.
// (R15) a started counter increments once per selected source enable.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module dtc_timer_ctrl
	import dtc_pkg::*;
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	// register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// system clock state
	input  wire logic       i_fs_tick,
	input  wire logic       i_divider_source_option,
	input  wire logic       i_slow_mode,
	// timer state
	output logic      [7:0] o_first_count,
	output logic      [7:0] o_second_count,
	output logic            o_first_ff,
	output logic            o_second_ff,
	output logic            o_first_overflow
);

	// ==========================================================
	// state
	dtc_byte_t                first_ctrl_reg, first_ctrl_next;
	dtc_byte_t                second_ctrl_reg, second_ctrl_next;
	dtc_byte_t                first_compare_reg, first_compare_next;
	dtc_byte_t                first_pulse_width_reg, first_pulse_width_next;
	dtc_byte_t                second_compare_reg, second_compare_next;
	dtc_byte_t                second_pulse_width_reg, second_pulse_width_next;
	dtc_byte_t                first_count_reg, first_count_next;
	dtc_byte_t                second_count_reg, second_count_next;
	dtc_byte_t                rdata_reg, rdata_next;
	dtc_run_e                 first_state_reg, first_state_next;
	dtc_run_e                 second_state_reg, second_state_next;
	logic                     first_ff_reg, first_ff_next;
	logic                     second_ff_reg, second_ff_next;
	logic                     ovf_reg, ovf_next;
	logic [DTC_PRE_W-1:0]     pre_reg, pre_next;
	logic [DTC_FS_DIV_W-1:0]  fs_div_reg, fs_div_next;

	logic       cascade, first_go, second_go, warmup_ok, first_ovf;
	logic       first_tick, second_sel_tick, second_tick;
	logic       fs_div3;
	logic [2:0] first_mode, second_mode;

	// ==========================================================
	// prescaler taps
	assign fs_div3 = i_fs_tick && (&fs_div_reg);

	always_comb begin
		pre_next    = pre_reg + 11'h001;
		fs_div_next = i_fs_tick ? fs_div_reg + 3'h1 : fs_div_reg;
	end

	// ==========================================================
	// mode decode
	assign first_mode  = dtc_mode_of(first_ctrl_reg);
	assign second_mode = dtc_mode_of(second_ctrl_reg);
	assign cascade     = (first_mode == DTC_M1_CASCADE); // R5
	// in cascade the lower byte follows the second start bit
	assign first_go    = cascade ? dtc_start_of(second_ctrl_reg) // R6
	                             : (dtc_start_of(first_ctrl_reg) && first_mode == DTC_M1_TIMER8); // R4
	assign second_go   = dtc_start_of(second_ctrl_reg) && second_mode != DTC_M2_RSVD; // R13
	assign warmup_ok   = cascade && second_mode == DTC_M2_WARMUP; // R2
	assign first_ovf   = first_state_reg == DTC_COUNTING && first_tick && first_count_reg == DTC_CNT_MAX;
	// with the second mode top bit set the upper byte ignores its own select and counts lower-byte overflows
	assign second_tick = second_mode[2] ? first_ovf : second_sel_tick; // R14

	dtc_src_sel u_first_sel (
		.i_code                  (dtc_ck_of(first_ctrl_reg)), // R1
		.i_divider_source_option (i_divider_source_option),
		.i_slow_mode             (i_slow_mode),
		.i_warmup_ok             (warmup_ok),
		.i_fc_div11              (&pre_reg[10:0]),
		.i_fc_div7               (&pre_reg[6:0]),
		.i_fc_div5               (&pre_reg[4:0]),
		.i_fc_div3               (&pre_reg[2:0]),
		.i_fc_div1               (pre_reg[0]),
		.i_fs_tick               (i_fs_tick),
		.i_fs_div3               (fs_div3),
		.o_tick                  (first_tick)
	);

	dtc_src_sel u_second_sel (
		.i_code                  (dtc_ck_of(second_ctrl_reg)), // R12
		.i_divider_source_option (i_divider_source_option),
		.i_slow_mode             (i_slow_mode),
		.i_warmup_ok             (1'b0),
		.i_fc_div11              (&pre_reg[10:0]),
		.i_fc_div7               (&pre_reg[6:0]),
		.i_fc_div5               (&pre_reg[4:0]),
		.i_fc_div3               (&pre_reg[2:0]),
		.i_fc_div1               (pre_reg[0]),
		.i_fs_tick               (i_fs_tick),
		.i_fs_div3               (fs_div3),
		.o_tick                  (second_sel_tick)
	);

	// ==========================================================
	// register writes
	always_comb begin
		first_ctrl_next         = first_ctrl_reg;
		second_ctrl_next        = second_ctrl_reg;
		first_compare_next      = first_compare_reg;
		first_pulse_width_next  = first_pulse_width_reg;
		second_compare_next     = second_compare_reg;
		second_pulse_width_next = second_pulse_width_reg;
		if (i_wr) begin
			case (i_addr)
				DTC_OFS_FIRST_CTRL: begin
					// while running only the start bit moves, so a stop keeps the setup
					if (first_state_reg == DTC_COUNTING) // R7 R8
						first_ctrl_next[DTC_START_BIT] = i_wdata[DTC_START_BIT]; // R3
					else
						first_ctrl_next = i_wdata;
				end
				DTC_OFS_SECOND_CTRL: begin
					if (dtc_start_of(second_ctrl_reg)) // R8
						second_ctrl_next[DTC_START_BIT] = i_wdata[DTC_START_BIT]; // R3
					else
						second_ctrl_next = i_wdata;
				end
				DTC_OFS_FIRST_CMP: begin
					if (first_state_reg == DTC_STOPPED) // R9
						first_compare_next = i_wdata;
				end
				DTC_OFS_SECOND_CMP: begin
					if (second_state_reg == DTC_STOPPED) // R9
						second_compare_next = i_wdata;
				end
				DTC_OFS_FIRST_PW: begin
					if (first_state_reg == DTC_STOPPED || (!cascade && second_mode == DTC_M2_PWM8) ||
					    (cascade && second_mode == DTC_M2_PWM16)) // R10
						first_pulse_width_next = i_wdata;
				end
				DTC_OFS_SECOND_PW: begin
					if (second_state_reg == DTC_STOPPED || second_mode == DTC_M2_PWM8 ||
					    second_mode == DTC_M2_PWM16) // R10
						second_pulse_width_next = i_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// counters and flip-flops
	always_comb begin
		first_state_next  = first_go ? DTC_COUNTING : DTC_STOPPED;
		second_state_next = second_go ? DTC_COUNTING : DTC_STOPPED;
		first_count_next  = first_count_reg;
		second_count_next = second_count_reg;
		first_ff_next     = first_ff_reg;
		second_ff_next    = second_ff_reg;
		ovf_next          = first_ovf;
		if (!first_go)
			first_count_next = 8'h00; // R3
		else if (first_state_reg == DTC_COUNTING && first_tick)
			first_count_next = first_count_reg + 8'h01; // R15
		if (!second_go)
			second_count_next = 8'h00; // R3
		else if (second_state_reg == DTC_COUNTING && second_tick)
			second_count_next = second_count_reg + 8'h01; // R15
		// initial level loads only while stopped; the flip-flop keeps its value while counting
		if (first_state_reg == DTC_STOPPED)
			first_ff_next = cascade ? second_ctrl_reg[DTC_FF_BIT] : first_ctrl_reg[DTC_FF_BIT]; // R6
		if (second_state_reg == DTC_STOPPED)
			second_ff_next = second_ctrl_reg[DTC_FF_BIT];
	end

	// ==========================================================
	// read port
	always_comb begin
		rdata_next = 8'h00;
		if (i_rd) begin
			case (i_addr)
				DTC_OFS_FIRST_CTRL:  rdata_next = first_ctrl_reg; // R11
				DTC_OFS_SECOND_CTRL: rdata_next = second_ctrl_reg;
				DTC_OFS_FIRST_CMP:   rdata_next = first_compare_reg;
				DTC_OFS_FIRST_PW:    rdata_next = first_pulse_width_reg;
				DTC_OFS_SECOND_CMP:  rdata_next = second_compare_reg;
				DTC_OFS_SECOND_PW:   rdata_next = second_pulse_width_reg;
				DTC_OFS_FIRST_CNT:   rdata_next = first_count_reg;
				DTC_OFS_SECOND_CNT:  rdata_next = second_count_reg;
				default:             rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			first_ctrl_reg         <= DTC_CTRL_RST;
			second_ctrl_reg        <= DTC_CTRL_RST;
			first_compare_reg      <= DTC_TREG_RST;
			first_pulse_width_reg  <= DTC_TREG_RST;
			second_compare_reg     <= DTC_TREG_RST;
			second_pulse_width_reg <= DTC_TREG_RST;
			first_count_reg        <= 8'h00;
			second_count_reg       <= 8'h00;
			rdata_reg              <= 8'h00;
			first_state_reg        <= DTC_STOPPED;
			second_state_reg       <= DTC_STOPPED;
			first_ff_reg           <= 1'b0;
			second_ff_reg          <= 1'b0;
			ovf_reg                <= 1'b0;
			pre_reg                <= '0;
			fs_div_reg             <= '0;
		end else begin
			first_ctrl_reg         <= first_ctrl_next;
			second_ctrl_reg        <= second_ctrl_next;
			first_compare_reg      <= first_compare_next;
			first_pulse_width_reg  <= first_pulse_width_next;
			second_compare_reg     <= second_compare_next;
			second_pulse_width_reg <= second_pulse_width_next;
			first_count_reg        <= first_count_next;
			second_count_reg       <= second_count_next;
			rdata_reg              <= rdata_next;
			first_state_reg        <= first_state_next;
			second_state_reg       <= second_state_next;
			first_ff_reg           <= first_ff_next;
			second_ff_reg          <= second_ff_next;
			ovf_reg                <= ovf_next;
			pre_reg                <= pre_next;
			fs_div_reg             <= fs_div_next;
		end
	end

	assign o_rdata          = rdata_reg;
	assign o_first_count    = first_count_reg;
	assign o_second_count   = second_count_reg;
	assign o_first_ff       = first_ff_reg;
	assign o_second_ff      = second_ff_reg;
	assign o_first_overflow = ovf_reg;

	// ==========================================================
	// assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	AST_STOP_CLEARS: assert property (!first_go |=> first_count_reg == 8'h00) // R3
		else $error("first counter not cleared while stopped");
	AST_SECOND_STOP: assert property (
		(i_wr && i_addr == DTC_OFS_SECOND_CTRL && !i_wdata[DTC_START_BIT]) |-> ##2 second_count_reg == 8'h00) // R3
		else $error("second counter not cleared after stop write");
	AST_RSVD_CK: assert property (
		(dtc_ck_of(first_ctrl_reg) == DTC_CK_RSVD && first_go) ##1 first_go |-> $stable(first_count_reg)) // R1
		else $error("first counter moved on reserved clock");
	AST_SLOW_CK: assert property (
		(i_slow_mode && dtc_ck_of(first_ctrl_reg) == DTC_CK_DIV3 && first_go) ##1 first_go
		|-> $stable(first_count_reg)) // R2
		else $error("fast source counted in slow operation");
	AST_RSVD_MODE: assert property (
		(first_mode != DTC_M1_TIMER8 && !cascade) |=> first_count_reg == 8'h00) // R4
		else $error("first counter ran in reserved mode");
	AST_CASCADE_STOP: assert property (
		(cascade && !dtc_start_of(second_ctrl_reg)) |=> first_count_reg == 8'h00) // R6
		else $error("lower byte ran without upper start bit");
	AST_UPPER_CLOCK: assert property (
		(second_mode[2] && second_go && !first_ovf) ##1 second_go |-> $stable(second_count_reg)) // R14
		else $error("upper byte counted without lower overflow");
	AST_CTRL_LOCK: assert property (
		(first_state_reg == DTC_COUNTING && i_wr && i_addr == DTC_OFS_FIRST_CTRL)
		|=> $stable(first_ctrl_reg[6:4]) && $stable(first_ctrl_reg[2:0])) // R7
		else $error("first setup changed while running");
	AST_CMP_LOCK: assert property (
		(first_state_reg == DTC_COUNTING && i_wr && i_addr == DTC_OFS_FIRST_CMP) |=> $stable(first_compare_reg)) // R9
		else $error("compare changed while running");
	AST_PW_PWM: assert property (
		(second_state_reg == DTC_COUNTING && second_mode == DTC_M2_PWM8 && i_wr && i_addr == DTC_OFS_SECOND_PW)
		|=> second_pulse_width_reg == $past(i_wdata)) // R10
		else $error("pulse width refused in PWM mode");
	AST_INC: assert property (
		(first_go && first_state_reg == DTC_COUNTING && first_tick) ##1 first_go
		|-> first_count_reg == $past(first_count_reg) + 8'h01) // R15
		else $error("first counter missed an increment");
	AST_FF_LOAD: assert property (
		(cascade && first_state_reg == DTC_STOPPED) |=> o_first_ff == $past(second_ctrl_reg[DTC_FF_BIT])) // R6
		else $error("lower flip-flop not loaded from upper control");
	AST_RDATA: assert property (
		(i_rd && i_addr == DTC_OFS_SECOND_CTRL) |=> o_rdata == $past(second_ctrl_reg)) // R11
		else $error("control readback wrong");

	COV_OVERFLOW: cover property (first_ovf);
	COV_CASCADE:  cover property (cascade && second_mode == DTC_M2_TIMER16 && second_tick);
	COV_WARMUP:   cover property (i_slow_mode && warmup_ok && first_tick && first_go);

endmodule // dtc_timer_ctrl

// *** verif/tb_top.sv ***
// self-checking bench for the dual 8-bit timer control block, with a register shadow model
// assumes the register port never stalls and read data stand only in the cycle after the strobe
`timescale 1ns/1ps
module tb_top
	import dtc_pkg::*;
;
	// ==========================================================
	// signals
	logic       i_clk;
	logic       i_reset;
	logic [7:0] i_addr;
	logic [7:0] i_wdata;
	logic       i_wr;
	logic       i_rd;
	logic [7:0] o_rdata;
	logic       i_fs_tick;
	logic       i_divider_source_option;
	logic       i_slow_mode;
	logic [7:0] o_first_count;
	logic [7:0] o_second_count;
	logic       o_first_ff;
	logic       o_second_ff;
	logic       o_first_overflow;
	int         n_mismatch;
	int         checks;
	int         n_ovf;
	int         fs;
	dtc_byte_t  mdl [8'h1A:8'h1F];
	dtc_byte_t  d;

	dtc_timer_ctrl u_dut (
		.i_clk                   (i_clk),
		.i_reset                 (i_reset),
		.i_addr                  (i_addr),
		.i_wdata                 (i_wdata),
		.i_wr                    (i_wr),
		.i_rd                    (i_rd),
		.o_rdata                 (o_rdata),
		.i_fs_tick               (i_fs_tick),
		.i_divider_source_option (i_divider_source_option),
		.i_slow_mode             (i_slow_mode),
		.o_first_count           (o_first_count),
		.o_second_count          (o_second_count),
		.o_first_ff              (o_first_ff),
		.o_second_ff             (o_second_ff),
		.o_first_overflow        (o_first_overflow)
	);

	// ==========================================================
	// clock, random low-frequency ticks, overflow tally
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		i_fs_tick <= ($urandom_range(3) == 0);
	end
	always @(posedge i_clk) begin
		if (o_first_overflow === 1'b1) n_ovf++;
	end

	// ==========================================================
	// shadow model: protected fields are dropped while running
	function automatic void mdl_wr(input dtc_byte_t a, input dtc_byte_t v);
		logic       r1;
		logic       r2;
		logic [2:0] m1;
		logic [2:0] m2;
		m1 = mdl[8'h1A][2:0];
		m2 = mdl[8'h1B][2:0];
		r2 = mdl[8'h1B][3];
		r1 = (m1 == 3'h3) ? r2 : mdl[8'h1A][3];
		case (a)
			8'h1A: mdl[a] = r1 ? {mdl[a][7:4], v[3], mdl[a][2:0]} : v;
			8'h1B: mdl[a] = r2 ? {mdl[a][7:4], v[3], mdl[a][2:0]} : v;
			8'h1C: if (!r1) mdl[a] = v;
			8'h1D: if (!r1 || (m2 == 3'h2 && m1 != 3'h3) || m2 == 3'h6) mdl[a] = v;
			8'h1E: if (!r2) mdl[a] = v;
			8'h1F: if (!r2 || m2 == 3'h2 || m2 == 3'h6) mdl[a] = v;
			default: ;
		endcase
	endfunction

	// expected count of a run of cyc cycles that saw fs low-frequency ticks
	function automatic int exp_cnt(input logic [2:0] k, input logic slow, input logic opt,
		input logic warm, input int cyc, input int fs);
		case (k)
			3'h0: return (slow || opt) ? fs / 8 : cyc / 2048;
			3'h1: return slow ? 0 : cyc / 128;
			3'h2: return slow ? 0 : cyc / 32;
			3'h3: return slow ? 0 : cyc / 8;
			3'h4: return fs;
			3'h5: return slow ? 0 : cyc / 2;
			3'h6: return (!slow || warm) ? cyc : 0;
			default: return 0;
		endcase
	endfunction

	// ==========================================================
	// bus and compare tasks
	task automatic wr(input dtc_byte_t a, input dtc_byte_t v);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
		mdl_wr(a, v);
	endtask

	task automatic rd(input dtc_byte_t a, output dtc_byte_t v);
		@(posedge i_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		// data stand in this cycle only; take them before the next edge replaces them
		@(posedge i_clk);
		v = o_rdata;
	endtask

	task automatic chk(input string name, input dtc_byte_t e, input dtc_byte_t g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, e, g);
		end
	endtask

	// counts drift by a tick or two with prescaler phase, hence the window
	task automatic near(input string name, input int e, input dtc_byte_t g, input int tol);
		int gi;
		gi = int'(g);
		checks++;
		if (^g === 1'bx || gi < e - tol || gi > e + tol) begin
			n_mismatch++;
			$display("MISMATCH %s expected %0d seen %h", name, e, g);
		end
	endtask

	task automatic run(input dtc_byte_t a, input dtc_byte_t v, input dtc_byte_t ca, input int n,
		output dtc_byte_t got);
		dtc_byte_t z;
		fs    = 0;
		n_ovf = 0;
		wr(a, v);
		repeat (n) begin
			@(posedge i_clk);
			if (i_fs_tick === 1'b1) fs++;
		end
		rd(ca, got);
		wr(a, v & 8'hF7);
		repeat (2) @(posedge i_clk);
		rd(ca, z);
		chk("cleared count", 8'h00, z);
		chk("first count port", 8'h00, o_first_count);
		chk("second count port", 8'h00, o_second_count);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#(8 * 40000);
		n_mismatch++;
		$display("watchdog expired");
		finish_test();
	end

	// ==========================================================
	// tests
	initial begin
		void'($urandom(32'hCE2F8375));
		{i_wr, i_rd, i_addr, i_wdata, i_divider_source_option, i_slow_mode} = '0;
		i_reset = 1'b1;
		foreach (mdl[a]) mdl[a] = 8'h00;
		repeat (10) @(posedge i_clk);
		i_reset <= 1'b0;
		for (int a = 8'h1A; a <= 8'h21; a++) begin
			rd(8'(a), d);
			chk("reset value", 8'h00, d);
		end
		@(posedge i_clk);
		chk("idle read data", 8'h00, o_rdata);
		wr(8'h30, 8'hFF);
		rd(8'h30, d);
		chk("unmapped read", 8'h00, d);
		$display("test reset done");
		for (int a = 8'h1A; a <= 8'h1F; a++) begin
			d = 8'($urandom);
			if (a < 8'h1C) d[3] = 1'b0;
			wr(8'(a), d);
			rd(8'(a), d);
			chk("register", mdl[a], d);
		end
		repeat (2) @(posedge i_clk);
		chk("second ff", {7'h00, mdl[8'h1B][7]}, {7'h00, o_second_ff});
		for (int a = 8'h1A; a <= 8'h1F; a++) wr(8'(a), 8'h00);
		$display("test registers done");
		for (int s = 0; s < 2; s++) for (int o = 0; o < 2; o++) for (int k = 0; k < 8; k++) begin
			i_slow_mode             <= s[0];
			i_divider_source_option <= o[0];
			run(8'h1B, {1'b0, 3'(k), 4'h8}, 8'h21, 200, d);
			near("second count", exp_cnt(3'(k), s[0], o[0], 1'b0, 202, fs), d, 3);
			run(8'h1A, {1'b0, 3'(k), 4'h8}, 8'h20, 200, d);
			near("first count", exp_cnt(3'(k), s[0], o[0], 1'b0, 202, fs), d, 3);
		end
		i_slow_mode             <= 1'b0;
		i_divider_source_option <= 1'b0;
		$display("test sources done");
		wr(8'h1A, 8'h68);
		wr(8'h1A, 8'h1B);
		wr(8'h1C, 8'($urandom));
		wr(8'h1D, 8'($urandom));
		wr(8'h1B, 8'h2A);
		wr(8'h1E, 8'($urandom));
		wr(8'h1F, 8'($urandom));
		for (int a = 8'h1A; a <= 8'h1F; a++) begin
			rd(8'(a), d);
			chk("running register", mdl[a], d);
		end
		wr(8'h1A, 8'h10);
		wr(8'h1B, 8'h00);
		for (int a = 8'h1A; a <= 8'h1B; a++) begin
			rd(8'(a), d);
			chk("stopping write", mdl[a], d);
		end
		// cascade in 16-bit PWM: both pulse widths take writes while running, the first compare does not
		wr(8'h1A, 8'h63);
		wr(8'h1B, 8'h0E);
		wr(8'h1C, 8'($urandom));
		wr(8'h1D, 8'($urandom));
		wr(8'h1F, 8'($urandom));
		wr(8'h1B, 8'h06);
		for (int a = 8'h1C; a <= 8'h1F; a++) begin
			rd(8'(a), d);
			chk("cascade register", mdl[a], d);
		end
		for (int a = 8'h1A; a <= 8'h1F; a++) wr(8'(a), 8'h00);
		$display("test protection done");
		wr(8'h1B, 8'h80);
		repeat (3) @(posedge i_clk);
		chk("second ff", 8'h01, {7'h00, o_second_ff});
		chk("first ff", 8'h00, {7'h00, o_first_ff});
		wr(8'h1A, 8'h63);
		repeat (3) @(posedge i_clk);
		chk("cascade first ff", 8'h01, {7'h00, o_first_ff});
		run(8'h1B, 8'h8C, 8'h21, 600, d);
		near("upper count", n_ovf, d, 1);
		near("overflows", 602 / 256, 8'(n_ovf), 1);
		i_slow_mode <= 1'b1;
		run(8'h1B, 8'h0D, 8'h20, 200, d);
		near("warm-up count", exp_cnt(3'h6, 1'b1, 1'b0, 1'b1, 202, fs), d, 3);
		i_slow_mode <= 1'b0;
		wr(8'h1B, 8'h00);
		wr(8'h1A, 8'h00);
		run(8'h1A, 8'h69, 8'h20, 200, d);
		near("reserved first mode", 0, d, 0);
		wr(8'h1A, 8'h00);
		run(8'h1B, 8'h6B, 8'h21, 200, d);
		near("reserved second mode", 0, d, 0);
		$display("test cascade done");
		finish_test();
	end
endmodule // tb_top
